// ### power_sign_and_error_flags.v
// Sticky sign change, energy ready and internal error flags behind an AHB-Lite slave.
// Assumes all inputs are synchronous to clk_sys_in and single word bus transfers.
//
// Notes on behaviour
// - Pulse output 4 flip flag, bit 10, sets when pulse polarity reverses.
// - Pulse flip flags are evaluated on the falling edge of the pulse output.
// - Pulse outputs 3, 2, 1 have the same flags at bits 9, 8, 7.
// - Reactive sign change flags per phase: C bit 6, B bit 5, A bit 4.
// - Sign select chooses total or fundamental reactive power for monitoring.
// - Reactive flags update only when accumulations refresh each power interval.
// - Active sign change flags per phase: C bit 3, B bit 2, A bit 1.
// - Active flags update when accumulations refresh each power interval.
// - Energy ready, bit 0, sets after energy interval of samples or line cycles.
// - Fatal faults at bits 31, 29, 28 raise a non-maskable interrupt until reset.
// - Corrected fault, bit 30, sets when an internal error was corrected.
//
// The implementer's own choice: the AHB-Lite slave port.
`include "sign_flags_defs.vh"

module power_sign_and_error_flags #(
    parameter [15:0] PWR_INTERVAL_DEFAULT = `PWR_INTERVAL_RST,
    parameter [15:0] EGY_INTERVAL_DEFAULT = `EGY_INTERVAL_RST
) (
    input  wire        clk_sys_in,
    input  wire        nrst_in,
    input  wire        hsel_in,
    input  wire [31:0] haddr_in,
    input  wire [1:0]  htrans_in,
    input  wire        hwrite_in,
    input  wire [2:0]  hsize_in,
    input  wire [31:0] hwdata_in,
    input  wire        hready_in,
    output wire [31:0] hrdata_out,
    output wire        hreadyout_out,
    output wire        hresp_out,
    input  wire [3:0]  pulse_level_in,
    input  wire [3:0]  pulse_polarity_in,
    input  wire        sample_tick_in,
    input  wire        line_cycle_tick_in,
    input  wire [2:0]  act_total_neg_in,
    input  wire [2:0]  act_fund_neg_in,
    input  wire [2:0]  react_total_neg_in,
    input  wire [2:0]  react_fund_neg_in,
    input  wire        fault_hi_in,
    input  wire        fault_mid_in,
    input  wire        fault_lo_in,
    input  wire        fault_corrected_in,
    output wire        irq_out,
    output wire        nmi_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations.

    reg                     ready_r;
    reg  [31:0]             rdata_r;
    reg                     wr_pend_r;
    reg  [`IDX_W-1:0]       wr_idx_r;
    reg                     sign_sel_r;
    reg                     tmr_mode_r;
    reg                     soft_clr_r;
    reg  [`INT_CNT_W-1:0]   pwr_int_r;
    reg  [`INT_CNT_W-1:0]   egy_int_r;
    reg  [`INT_CNT_W-1:0]   egy_cnt_r;
    reg                     egy_evt_r;
    reg  [`F1_USED_W-1:0]   flags1_r;
    reg  [`F1_USED_W-1:0]   flags1_nxt;
    reg                     corr_r;
    reg                     fat_hi_r;
    reg                     fat_mid_r;
    reg                     fat_lo_r;
    reg  [`IRQ_W-1:0]       irq_stat_r;
    reg  [`IRQ_W-1:0]       irq_stat_nxt;
    reg  [`IRQ_W-1:0]       irq_mask_r;
    reg                     irq_r;
    reg                     nmi_r;
    reg  [31:0]             rd_mux;

    wire [3:0]              pulse_evt;
    wire [2:0]              act_evt;
    wire [2:0]              react_evt;
    wire [`F1_USED_W-1:0]   set1;
    wire [`F1_USED_W-1:0]   clr1;
    wire [`IRQ_W-1:0]       irq_set;
    wire [31:0]             flags2_word;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus address phase decode.

    // True when the word address selects the given register index.
    function hit;
        input [31:0]       addr;
        input [`IDX_W-1:0] idx;
        begin
            hit = (addr[31:2] == {19'h00000, idx});
        end
    endfunction

    wire        acc     = hsel_in & hready_in & (htrans_in == `HTRANS_NONSEQ);
    wire        rd_acc  = acc & ~hwrite_in;
    wire        wr_acc  = acc & hwrite_in;
    wire        rd_irq  = rd_acc & hit(haddr_in, `IDX_IRQ_STATUS);

    wire        wr_ctrl = wr_pend_r & (wr_idx_r == `IDX_CTRL);
    wire        wr_int  = wr_pend_r & (wr_idx_r == `IDX_INTERVALS);
    wire        wr_f1   = wr_pend_r & (wr_idx_r == `IDX_FLAGS_FIRST);
    wire        wr_f2   = wr_pend_r & (wr_idx_r == `IDX_FLAGS_SECOND);
    wire        wr_mask = wr_pend_r & (wr_idx_r == `IDX_IRQ_MASK);

    assign hrdata_out    = rdata_r;
    assign hreadyout_out = ready_r;
    assign hresp_out     = `HRESP_OKAY;

    ////////////////////////////////////////////////////////////////////////////////
    // Event sources.

    pulse_sign_tracker #(
        .NUM_OUT (4)
    ) u_pulse (
        .clk_sys_in        (clk_sys_in),
        .nrst_in           (nrst_in),
        .soft_clr_in       (soft_clr_r),
        .pulse_level_in    (pulse_level_in),
        .pulse_polarity_in (pulse_polarity_in),
        .flip_evt_out      (pulse_evt)
    );

    power_sign_monitor #(
        .PHASES (3),
        .CNT_W  (`INT_CNT_W)
    ) u_power (
        .clk_sys_in         (clk_sys_in),
        .nrst_in            (nrst_in),
        .soft_clr_in        (soft_clr_r),
        .sample_tick_in     (sample_tick_in),
        .interval_in        (pwr_int_r),
        .sign_sel_in        (sign_sel_r),
        .act_total_neg_in   (act_total_neg_in),
        .act_fund_neg_in    (act_fund_neg_in),
        .react_total_neg_in (react_total_neg_in),
        .react_fund_neg_in  (react_fund_neg_in),
        .act_evt_out        (act_evt),
        .react_evt_out      (react_evt)
    );

    // Energy interval counts samples or line cycles depending on the timer mode.
    wire egy_tick = tmr_mode_r ? line_cycle_tick_in : sample_tick_in;

    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            egy_cnt_r <= {`INT_CNT_W{1'b0}};
            egy_evt_r <= 1'b0;
        end else if (soft_clr_r) begin
            egy_cnt_r <= {`INT_CNT_W{1'b0}};
            egy_evt_r <= 1'b0;
        end else begin
            egy_evt_r <= egy_tick & (egy_cnt_r >= egy_int_r);
            if (egy_tick) begin
                if (egy_cnt_r >= egy_int_r) begin
                    egy_cnt_r <= {`INT_CNT_W{1'b0}};
                end else begin
                    egy_cnt_r <= egy_cnt_r + {{(`INT_CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // First flag word: set wins over a write-one clear.

    assign set1 = {pulse_evt, react_evt, act_evt, egy_evt_r};
    assign clr1 = wr_f1 ? hwdata_in[`F1_USED_MSB:0] : {`F1_USED_W{1'b0}};

    always @* begin
        flags1_nxt = (flags1_r & ~clr1) | set1;
    end

    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            flags1_r <= {`F1_USED_W{1'b0}};
        end else if (soft_clr_r) begin
            flags1_r <= {`F1_USED_W{1'b0}};
        end else begin
            flags1_r <= flags1_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Second flag word: corrected fault clears by write-one, fatal faults only by reset.

    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            corr_r    <= 1'b0;
            fat_hi_r  <= 1'b0;
            fat_mid_r <= 1'b0;
            fat_lo_r  <= 1'b0;
        end else if (soft_clr_r) begin
            corr_r    <= 1'b0;
            fat_hi_r  <= 1'b0;
            fat_mid_r <= 1'b0;
            fat_lo_r  <= 1'b0;
        end else begin
            corr_r    <= fault_corrected_in | (corr_r & ~(wr_f2 & hwdata_in[`F2_CORRECTED]));
            fat_hi_r  <= fat_hi_r | fault_hi_in;
            fat_mid_r <= fat_mid_r | fault_mid_in;
            fat_lo_r  <= fat_lo_r | fault_lo_in;
        end
    end

    assign flags2_word = {fat_hi_r, corr_r, fat_mid_r, fat_lo_r, 28'h0000000};

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status, cleared by a read, set winning over the clear.

    assign irq_set = {fault_corrected_in, set1};

    always @* begin
        irq_stat_nxt = (rd_irq ? {`IRQ_W{1'b0}} : irq_stat_r) | irq_set;
    end

    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_stat_r <= {`IRQ_W{1'b0}};
            irq_r      <= 1'b0;
            nmi_r      <= 1'b0;
        end else begin
            irq_stat_r <= soft_clr_r ? {`IRQ_W{1'b0}} : irq_stat_nxt;
            irq_r      <= |(irq_stat_nxt & irq_mask_r) & ~soft_clr_r;
            // Fatal faults bypass the mask.
            nmi_r      <= (fat_hi_r | fat_mid_r | fat_lo_r | fault_hi_in | fault_mid_in
                           | fault_lo_in) & ~soft_clr_r;
        end
    end

    assign irq_out = irq_r;
    assign nmi_out = nmi_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers and bus pipeline.

    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ready_r    <= 1'b0;
            wr_pend_r  <= 1'b0;
            wr_idx_r   <= {`IDX_W{1'b0}};
            sign_sel_r <= 1'b0;
            tmr_mode_r <= 1'b0;
            soft_clr_r <= 1'b0;
            pwr_int_r  <= PWR_INTERVAL_DEFAULT;
            egy_int_r  <= EGY_INTERVAL_DEFAULT;
            irq_mask_r <= {`IRQ_W{1'b0}};
        end else begin
            ready_r    <= 1'b1;
            wr_pend_r  <= wr_acc;
            wr_idx_r   <= haddr_in[`IDX_W+1:2];
            soft_clr_r <= wr_ctrl & hwdata_in[`CTRL_SOFT_RST_BIT];
            if (wr_pend_r & (haddr_in[31:`IDX_W+2] != 19'h00000)) begin
                wr_idx_r <= wr_idx_r;
            end
            if (wr_ctrl) begin
                sign_sel_r <= hwdata_in[`CTRL_SIGN_SEL_BIT];
                tmr_mode_r <= hwdata_in[`CTRL_TMR_MODE_BIT];
            end
            if (wr_int) begin
                pwr_int_r <= hwdata_in[`INT_PWR_LSB+`INT_CNT_W-1:`INT_PWR_LSB];
                egy_int_r <= hwdata_in[`INT_EGY_LSB+`INT_CNT_W-1:`INT_EGY_LSB];
            end
            if (wr_mask) begin
                irq_mask_r <= hwdata_in[`IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data, captured in the address phase; unmapped addresses read as zero.

    always @* begin
        rd_mux = 32'h00000000;
        if (hit(haddr_in, `IDX_CTRL)) begin
            rd_mux = {30'h00000000, tmr_mode_r, sign_sel_r};
        end else if (hit(haddr_in, `IDX_INTERVALS)) begin
            rd_mux = {egy_int_r, pwr_int_r};
        end else if (hit(haddr_in, `IDX_FLAGS_FIRST)) begin
            rd_mux = {21'h000000, flags1_r};
        end else if (hit(haddr_in, `IDX_FLAGS_SECOND)) begin
            rd_mux = flags2_word;
        end else if (hit(haddr_in, `IDX_IRQ_STATUS)) begin
            rd_mux = {20'h00000, irq_stat_r};
        end else if (hit(haddr_in, `IDX_IRQ_MASK)) begin
            rd_mux = {20'h00000, irq_mask_r};
        end
    end

    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_r <= 32'h00000000;
        end else if (rd_acc) begin
            rdata_r <= rd_mux;
        end
    end

endmodule

// ### sign_flags_defs.vh
// Constants for the power sign and error flag bank.
// Assumes a 32-bit AHB-Lite register bus; indices are word indices, byte address is index * 4.
`ifndef SIGN_FLAGS_DEFS_VH
`define SIGN_FLAGS_DEFS_VH

// Register word indices.
`define IDX_W               11
`define IDX_CTRL            11'h400
`define IDX_INTERVALS       11'h401
`define IDX_FLAGS_FIRST     11'h402
`define IDX_FLAGS_SECOND    11'h403
`define IDX_IRQ_STATUS      11'h404
`define IDX_IRQ_MASK        11'h405

// Control register fields.
`define CTRL_SIGN_SEL_BIT   0
`define CTRL_TMR_MODE_BIT   1
`define CTRL_SOFT_RST_BIT   2

// Interval register fields.
`define INT_PWR_LSB         0
`define INT_EGY_LSB         16
`define INT_CNT_W           16
`define PWR_INTERVAL_RST    16'h00ff
`define EGY_INTERVAL_RST    16'h00ff

// First flag word fields.
`define F1_ENERGY_READY     0
`define F1_ACT_LSB          1
`define F1_REACT_LSB        4
`define F1_PULSE_LSB        7
`define F1_USED_MSB         10
`define F1_USED_W           11

// Second flag word fields.
`define F2_FATAL_LO         28
`define F2_FATAL_MID        29
`define F2_CORRECTED        30
`define F2_FATAL_HI         31

// Interrupt status and mask layout.
`define IRQ_CORRECTED       11
`define IRQ_W               12

// Bus encodings.
`define HTRANS_NONSEQ       2'h2
`define HRESP_OKAY          1'h0

`endif

// ### pulse_sign_tracker.v
// Per pulse output sign reversal detector.
// Assumes pulse levels and polarities are synchronous to clk_sys_in.
`include "sign_flags_defs.vh"

module pulse_sign_tracker #(
    parameter NUM_OUT = 4
) (
    input  wire               clk_sys_in,
    input  wire               nrst_in,
    input  wire               soft_clr_in,
    input  wire [NUM_OUT-1:0] pulse_level_in,
    input  wire [NUM_OUT-1:0] pulse_polarity_in,
    output wire [NUM_OUT-1:0] flip_evt_out
);

    reg [NUM_OUT-1:0] level_prev_r;
    reg [NUM_OUT-1:0] pol_prev_r;
    reg [NUM_OUT-1:0] seen_r;
    reg [NUM_OUT-1:0] evt_r;

    assign flip_evt_out = evt_r;

    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g = g + 1) begin : chan
            // A pulse is issued on the high to low edge of its output.
            wire fall = level_prev_r[g] & ~pulse_level_in[g];

            always @(posedge clk_sys_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    level_prev_r[g] <= 1'b0;
                    pol_prev_r[g]   <= 1'b0;
                    seen_r[g]       <= 1'b0;
                    evt_r[g]        <= 1'b0;
                end else if (soft_clr_in) begin
                    level_prev_r[g] <= pulse_level_in[g];
                    pol_prev_r[g]   <= 1'b0;
                    seen_r[g]       <= 1'b0;
                    evt_r[g]        <= 1'b0;
                end else begin
                    level_prev_r[g] <= pulse_level_in[g];
                    // Compare with the previous pulse only on a falling edge.
                    evt_r[g] <= fall & seen_r[g] & (pulse_polarity_in[g] != pol_prev_r[g]);
                    if (fall) begin
                        pol_prev_r[g] <= pulse_polarity_in[g];
                        seen_r[g]     <= 1'b1;
                    end
                end
            end
        end
    endgenerate

endmodule

// ### power_sign_monitor.v
// Per phase active and reactive power sign change detector with its refresh timer.
// Assumes sign inputs are 1 for negative power and sample_tick_in pulses at 8 kSPS.
`include "sign_flags_defs.vh"

module power_sign_monitor #(
    parameter PHASES = 3,
    parameter CNT_W  = 16
) (
    input  wire              clk_sys_in,
    input  wire              nrst_in,
    input  wire              soft_clr_in,
    input  wire              sample_tick_in,
    input  wire [CNT_W-1:0]  interval_in,
    input  wire              sign_sel_in,
    input  wire [PHASES-1:0] act_total_neg_in,
    input  wire [PHASES-1:0] act_fund_neg_in,
    input  wire [PHASES-1:0] react_total_neg_in,
    input  wire [PHASES-1:0] react_fund_neg_in,
    output wire [PHASES-1:0] act_evt_out,
    output wire [PHASES-1:0] react_evt_out
);

    reg [CNT_W-1:0]  cnt_r;
    reg              seen_r;
    reg [PHASES-1:0] act_prev_r;
    reg [PHASES-1:0] react_prev_r;
    reg [PHASES-1:0] act_evt_r;
    reg [PHASES-1:0] react_evt_r;

    // Selects the fundamental source when sel is set, the total otherwise.
    function pick;
        input sel;
        input tot;
        input fund;
        begin
            pick = sel ? fund : tot;
        end
    endfunction

    // Accumulations refresh after interval_in + 1 sample ticks.
    wire refresh = sample_tick_in & (cnt_r >= interval_in);

    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_r  <= {CNT_W{1'b0}};
            seen_r <= 1'b0;
        end else if (soft_clr_in) begin
            cnt_r  <= {CNT_W{1'b0}};
            seen_r <= 1'b0;
        end else if (sample_tick_in) begin
            if (refresh) begin
                cnt_r  <= {CNT_W{1'b0}};
                seen_r <= 1'b1;
            end else begin
                cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    assign act_evt_out   = act_evt_r;
    assign react_evt_out = react_evt_r;

    genvar g;
    generate
        for (g = 0; g < PHASES; g = g + 1) begin : ph
            wire act_now = pick(sign_sel_in, act_total_neg_in[g], act_fund_neg_in[g]);
            wire rea_now = pick(sign_sel_in, react_total_neg_in[g], react_fund_neg_in[g]);

            always @(posedge clk_sys_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    act_prev_r[g]   <= 1'b0;
                    react_prev_r[g] <= 1'b0;
                    act_evt_r[g]    <= 1'b0;
                    react_evt_r[g]  <= 1'b0;
                end else if (soft_clr_in) begin
                    act_prev_r[g]   <= 1'b0;
                    react_prev_r[g] <= 1'b0;
                    act_evt_r[g]    <= 1'b0;
                    react_evt_r[g]  <= 1'b0;
                end else begin
                    // Signs are only compared on a refresh of the accumulations.
                    act_evt_r[g]   <= refresh & seen_r & (act_now != act_prev_r[g]);
                    react_evt_r[g] <= refresh & seen_r & (rea_now != react_prev_r[g]);
                    if (refresh) begin
                        act_prev_r[g]   <= act_now;
                        react_prev_r[g] <= rea_now;
                    end
                end
            end
        end
    endgenerate

endmodule

// ### sign_flags_checker_properties.sv
// Concurrent checks on bus, interrupt and fault outputs.
// Assumes binding into the flag bank; sees only its ports.
module sign_flags_checker (
    input wire        clk_sys_in,
    input wire        nrst_in,
    input wire        hsel_in,
    input wire [31:0] haddr_in,
    input wire [1:0]  htrans_in,
    input wire        hwrite_in,
    input wire        hready_in,
    input wire [31:0] hrdata_out,
    input wire        hreadyout_out,
    input wire        hresp_out,
    input wire        fault_hi_in,
    input wire        fault_mid_in,
    input wire        fault_lo_in,
    input wire        irq_out,
    input wire        nmi_out
);
    ////////////////////////////////////////
    wire       take_w = hsel_in && hready_in && htrans_in == 2'h2;
    wire       wr_w   = take_w && hwrite_in;
    wire       flt_w  = fault_hi_in || fault_mid_in || fault_lo_in;
    reg  [3:0] wr_hist_r;
    reg  [3:0] acc_hist_r;
    reg        mask_seen_r;

    // Recent bus history, since clears land a few cycles after the transfer.
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_hist_r   <= 4'h0;
            acc_hist_r  <= 4'h0;
            mask_seen_r <= 1'b0;
        end else begin
            wr_hist_r  <= {wr_hist_r[2:0], wr_w};
            acc_hist_r <= {acc_hist_r[2:0], take_w};
            if (wr_w && haddr_in == 32'h1014) begin
                mask_seen_r <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    a_resp_okay: assert property (hresp_out == 1'b0) else $error("bad response");
    a_ready_high: assert property ($past(nrst_in) |-> hreadyout_out) else $error("wait state");
    a_rdata_hold: assert property (!$past(take_w && !hwrite_in) |-> $stable(hrdata_out))
        else $error("read data moved");
    a_fault_nmi: assert property (flt_w |=> nmi_out) else $error("fault lost");
    a_nmi_cause: assert property ($rose(nmi_out) |-> $past(flt_w))
        else $error("stray nmi");
    a_nmi_sticky: assert property (nmi_out && wr_hist_r == 4'h0 && !wr_w |=> nmi_out)
        else $error("nmi dropped");
    a_irq_fall: assert property ($fell(irq_out) |-> acc_hist_r != 4'h0)
        else $error("irq fell alone");
    a_irq_masked: assert property (irq_out |-> mask_seen_r) else $error("irq unmasked");
endmodule

bind power_sign_and_error_flags sign_flags_checker u_chk (.*);

// ### host_bus_model.sv
// Host model: single word AHB-Lite transfers.
// Assumes one slave; its hreadyout is hready.
module host_bus_model (
    input  wire        clk_sys_in,
    input  wire        hready_in,
    input  wire [31:0] hrdata_in,
    output reg         hsel_out    = 1'b0,
    output reg  [31:0] haddr_out   = 32'h0,
    output reg  [1:0]  htrans_out  = 2'h0,
    output reg         hwrite_out  = 1'b0,
    output reg  [2:0]  hsize_out   = 3'h2,
    output reg  [31:0] hwdata_out  = 32'h0,
    output reg         timeout_out = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    ////////////////////////////////////////
    task wait_rdy;
        integer n;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys_in);
            if (hready_in === 1'b1) return;
        end
        timeout_out <= 1'b1;
    endtask

    // Released address and data lines carry the inverse, never the old value.
    task xfer(input bit w, input [31:0] a, input [31:0] d, output [31:0] q);
        @(posedge clk_sys_in);
        hsel_out   <= 1'b1;
        haddr_out  <= a;
        htrans_out <= 2'h2;
        hwrite_out <= w;
        wait_rdy;
        hsel_out   <= 1'b0;
        htrans_out <= 2'h0;
        haddr_out  <= ~a;
        hwdata_out <= d;
        wait_rdy;
        q = hrdata_in;
        hwdata_out <= ~d;
    endtask
endmodule

// ### tb.sv
// Self-checking bench for the flag bank.
// Assumes the host model drives the bus; this module drives the events.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    ////////////////////////////////////////
    localparam [31:0] A_CTRL = 32'h1000, A_INT = 32'h1004, A_F1 = 32'h1008;
    localparam [31:0] A_F2 = 32'h100c, A_IST = 32'h1010, A_MSK = 32'h1014;
    localparam logic [31:0] ADDR_T [7] = '{A_CTRL, A_INT, A_F1, A_F2, A_IST, A_MSK, 32'h2000};
    localparam logic [31:0] RST_T  [7] = '{0, 32'h00ff00ff, 0, 0, 0, 0, 0};
    reg         clk_sys_in = 1'b0;
    reg         nrst_in    = 1'b0;
    reg  [3:0]  lvl        = 4'h0;
    reg  [3:0]  pol        = 4'h0;
    reg         smp        = 1'b0;
    reg         line       = 1'b0;
    reg  [11:0] sgn        = 12'h0;
    reg  [2:0]  fault      = 3'h0;
    reg         corr       = 1'b0;
    wire        hsel_w, hwrite_w, hready_w, hresp_w, irq_w, nmi_w, to_w;
    wire [31:0] haddr_w, hwdata_w, hrdata_w;
    wire [1:0]  htrans_w;
    wire [2:0]  hsize_w;
    integer     err_count = 0;
    integer     compares  = 0;
    integer     i, s;
    reg  [31:0] q, r, e;
    reg  [3:0]  pp;
    reg  [2:0]  pa, pr, ea, er;

    always #20 clk_sys_in = ~clk_sys_in;

    host_bus_model u_host (.*, .hready_in(hready_w), .hrdata_in(hrdata_w),
        .hsel_out(hsel_w), .haddr_out(haddr_w), .htrans_out(htrans_w), .hwrite_out(hwrite_w),
        .hsize_out(hsize_w), .hwdata_out(hwdata_w), .timeout_out(to_w));
    power_sign_and_error_flags u_dut (.*,
        .hsel_in(hsel_w), .haddr_in(haddr_w), .htrans_in(htrans_w), .hwrite_in(hwrite_w),
        .hsize_in(hsize_w), .hwdata_in(hwdata_w), .hready_in(hready_w), .hrdata_out(hrdata_w),
        .hreadyout_out(hready_w), .hresp_out(hresp_w), .pulse_level_in(lvl),
        .pulse_polarity_in(pol), .sample_tick_in(smp), .line_cycle_tick_in(line),
        .act_total_neg_in(sgn[11:9]), .act_fund_neg_in(sgn[8:6]),
        .react_total_neg_in(sgn[5:3]), .react_fund_neg_in(sgn[2:0]),
        .fault_hi_in(fault[2]), .fault_mid_in(fault[1]), .fault_lo_in(fault[0]),
        .fault_corrected_in(corr), .irq_out(irq_w), .nmi_out(nmi_w));

    task results;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task chk(input string nm, input [31:0] ex, input [31:0] got);
        compares = compares + 1;
        if (got !== ex) begin
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
            err_count = err_count + 1;
        end
    endtask

    task rd(input [31:0] a, input [31:0] ex, input string nm);
        u_host.xfer(1'b0, a, 32'h0, q);
        chk(nm, ex, q);
    endtask

    task wr(input [31:0] a, input [31:0] d);
        u_host.xfer(1'b1, a, d, q);
    endtask

    task cyc(input integer n);
        repeat (n) @(posedge clk_sys_in);
    endtask

    task tick(input integer n, input bit ln);
        repeat (n) begin
            @(posedge clk_sys_in);
            line <= ln;
            smp  <= !ln;
            @(posedge clk_sys_in);
            line <= 1'b0;
            smp  <= 1'b0;
        end
        cyc(3);
    endtask

    // Polarity flips while the output rests low, which must not count.
    task pulse(input [3:0] p);
        @(posedge clk_sys_in);
        lvl <= 4'hf;
        pol <= p;
        cyc(2);
        lvl <= 4'h0;
        cyc(2);
        pol <= ~p;
        cyc(3);
    endtask

    function [2:0] pick(input sel, input [2:0] tot, input [2:0] fund);
        pick = sel ? fund : tot;
    endfunction

    always @(posedge to_w) begin
        $display("[ERR] hready expected 1 seen %b", hready_w);
        err_count = err_count + 1;
        results;
    end

    initial begin
        r = $urandom(1);
        cyc(4);
        nrst_in <= 1'b1;
        cyc(2);
        for (i = 0; i < 7; i++) rd(ADDR_T[i], RST_T[i], "reset value");
        wr(A_INT, 32'h00020003);
        rd(A_INT, 32'h00020003, "intervals");
        wr(32'h2000, 32'hffffffff);
        rd(32'h2000, 32'h0, "unmapped");
        for (i = 0; i < 8; i++) begin
            r = $urandom;
            if (i == 1) r[3:0] = ~pp;
            pulse(r[3:0]);
            e = (i == 0) ? 32'h0 : {21'h0, r[3:0] ^ pp, 7'h0};
            rd(A_F1, e, "pulse flips");
            if (i == 1) begin
                wr(A_F1, 32'h0);
                rd(A_F1, e, "write zero");
            end
            pp = r[3:0];
            wr(A_F1, 32'h7ff);
        end
        for (s = 0; s < 2; s++) begin
            wr(A_CTRL, s | 6);
            for (i = 0; i < 5; i++) begin
                r = $urandom;
                @(posedge clk_sys_in);
                sgn <= r[11:0];
                tick(3, 1'b0);
                rd(A_F1, 32'h0, "between refreshes");
                tick(1, 1'b0);
                ea = pick(s[0], r[11:9], r[8:6]);
                er = pick(s[0], r[5:3], r[2:0]);
                e = (i == 0) ? 32'h0 : {25'h0, er ^ pr, ea ^ pa, 1'b0};
                rd(A_F1, e, "power signs");
                pa = ea;
                pr = er;
                wr(A_F1, 32'h7f);
            end
        end
        wr(A_CTRL, 32'h6);
        tick(3, 1'b0);
        tick(2, 1'b1);
        rd(A_F1, 32'h0, "energy early");
        tick(1, 1'b1);
        rd(A_F1, 32'h1, "energy line");
        wr(A_F1, 32'h1);
        u_host.xfer(1'b0, A_IST, 32'h0, q);
        @(posedge clk_sys_in);
        corr <= 1'b1;
        @(posedge clk_sys_in);
        corr <= 1'b0;
        cyc(4);
        chk("masked irq", 32'h0, {31'h0, irq_w});
        wr(A_MSK, 32'h800);
        cyc(3);
        chk("irq", 32'h1, {31'h0, irq_w});
        rd(A_IST, 32'h800, "irq status");
        cyc(3);
        chk("irq cleared", 32'h0, {31'h0, irq_w});
        rd(A_F2, 32'h40000000, "corrected");
        wr(A_F2, 32'h40000000);
        rd(A_F2, 32'h0, "corrected clear");
        e = 32'h0;
        for (i = 0; i < 3; i++) begin
            @(posedge clk_sys_in);
            fault[i] <= 1'b1;
            @(posedge clk_sys_in);
            fault[i] <= 1'b0;
            cyc(3);
            e = e | (32'h1 << (28 + i + (i == 2)));
            rd(A_F2, e, "fatal flags");
            chk("nmi", 32'h1, {31'h0, nmi_w});
        end
        wr(A_F2, 32'hffffffff);
        rd(A_F2, 32'hb0000000, "fatal kept");
        wr(A_CTRL, 32'h4);
        cyc(3);
        chk("nmi after soft reset", 32'h0, {31'h0, nmi_w});
        rd(A_F2, 32'h0, "soft reset");
        tick(2, 1'b0);
        rd(A_F1, 32'h0, "energy samples early");
        tick(1, 1'b0);
        rd(A_F1, 32'h1, "energy samples");
        results;
    end
endmodule
